// ---- hw/sampm_pin_mux.sv ----
// Purpose: Shares package pins among audio, serial, codec, memory and GPIO
// Assumes: 125 MHz ref_clk_in, async active-low reset
// Notes:   Routing is combinational; port E input is filtered
// Operation
// [R1] Serial select bit picks second serial port or codec on shared pins.
// [R2] Audio select bit puts digital audio port on shared pins instead.
// [R3] Shared clock pin carries audio, serial or codec bit clock.
// [R4] Shared transmit pin drives audio, serial or codec data out.
// [R5] Shared receive pin feeds audio, serial or codec data in.
// [R6] Shared transmit frame pin carries channel select, frame or codec sync.
// [R7] Receive frame pin feeds master clock or serial frame; unused in codec.
// [R8] Static output enable pin doubles as dynamic column strobe.
// [R9] Static write enable pin doubles as dynamic write enable.
// [R10] Static direction pin doubles as dynamic row strobe.
// [R11] Address bits 27..15 carry dynamic address bits 0..12.
// [R12] Address bits 14..13 carry dynamic address bits 13..14.
// [R13] Port D bits 7..6 may carry dynamic byte masks 1..0.
// [R14] Run indicator pin may output clock enable instead.
// [R15] Media change interrupt input shares pin with boot ROM select.
// [R16] Port D bit 0 may carry the LED blinker output.
// [R17] Port E bits 1..0 share pins with boot width straps.
// [R18] Port E bit 2 shares its pin with clock source strap.
// [R19] Shared memory pins follow the memory cycle in progress.
// [R20] Straps sampled during reset; pins are GPIO afterwards.
`timescale 1ns/100ps
module sampm_pin_mux
	import sampm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                    ref_clk_in,
	input  wire logic                    nrst_in,
	input  wire logic                    clk_en_in,
	// Mode configuration
	input  wire logic                    serial_function_select_in,
	input  wire logic                    audio_function_select_in,
	// Shared serial pins
	input  wire logic                    ser_clk_pin_in,
	output logic                         ser_clk_pin_out,
	output logic                         ser_clk_pin_oe_out,
	output logic                         ser_txd_pin_out,
	input  wire logic                    ser_rxd_pin_in,
	input  wire logic                    ser_txfr_pin_in,
	output logic                         ser_txfr_pin_out,
	output logic                         ser_txfr_pin_oe_out,
	input  wire logic                    ser_rxfr_pin_in,
	// Audio port side
	input  wire logic                    aud_bclk_in,
	input  wire logic                    aud_bclk_oe_in,
	output logic                         aud_bclk_out,
	input  wire logic                    aud_sdo_in,
	output logic                         aud_sdi_out,
	input  wire logic                    aud_lr_in,
	input  wire logic                    aud_lr_oe_in,
	output logic                         aud_lr_out,
	output logic                         aud_mclk_out,
	// Second serial port side
	input  wire logic                    ssp_clk_in,
	input  wire logic                    ssp_clk_oe_in,
	output logic                         ssp_clk_out,
	input  wire logic                    ssp_txd_in,
	output logic                         ssp_rxd_out,
	input  wire logic                    ssp_txfr_in,
	input  wire logic                    ssp_txfr_oe_in,
	output logic                         ssp_txfr_out,
	output logic                         ssp_rxfr_out,
	// Codec side
	input  wire logic                    cdc_clk_in,
	input  wire logic                    cdc_clk_oe_in,
	output logic                         cdc_clk_out,
	input  wire logic                    cdc_dout_in,
	output logic                         cdc_din_out,
	input  wire logic                    cdc_sync_in,
	input  wire logic                    cdc_sync_oe_in,
	output logic                         cdc_sync_out,
	// Static memory controller side
	input  wire logic                    st_active_in,
	input  wire logic                    st_oe_n_in,
	input  wire logic                    st_we_n_in,
	input  wire logic                    st_write_in,
	input  wire logic [SAMPM_ADDR_W-1:0] st_addr_in,
	// Dynamic memory controller side
	input  wire logic                    dyn_active_in,
	input  wire logic                    dyn_cas_n_in,
	input  wire logic                    dyn_we_n_in,
	input  wire logic                    dyn_ras_n_in,
	input  wire logic [SAMPM_DRA_W-1:0]  dyn_addr_in,
	input  wire logic [1:0]              dyn_mask_in,
	input  wire logic                    dyn_mask_en_in,
	// Memory pins
	output logic                         mem_oe_pin_out,
	output logic                         mem_we_pin_out,
	output logic                         mem_dir_pin_out,
	output logic [SAMPM_ADDR_W-1:0]      mem_addr_pin_out,
	// Port D
	input  wire logic [SAMPM_PD_W-1:0]   pd_gpio_out_in,
	input  wire logic [SAMPM_PD_W-1:0]   pd_gpio_oe_in,
	input  wire logic [SAMPM_PD_W-1:0]   pd_pin_in,
	output logic [SAMPM_PD_W-1:0]        pd_pin_out,
	output logic [SAMPM_PD_W-1:0]        pd_pin_oe_out,
	output logic [SAMPM_PD_W-1:0]        pd_gpio_in_out,
	input  wire logic                    led_blink_in,
	input  wire logic                    led_en_in,
	// Run / clock enable pin
	input  wire logic                    run_in,
	input  wire logic                    clock_enable_out_in,
	input  wire logic                    clock_enable_out_sel_in,
	output logic                         run_pin_out,
	// Media change / boot ROM pin
	input  wire logic                    medchg_pin_in,
	output logic                         media_change_irq_out,
	output logic                         boot_rom_select_out,
	// Port E and straps
	input  wire logic [SAMPM_PE_W-1:0]   pe_gpio_out_in,
	input  wire logic [SAMPM_PE_W-1:0]   pe_gpio_oe_in,
	input  wire logic [SAMPM_PE_W-1:0]   pe_pin_in,
	output logic [SAMPM_PE_W-1:0]        pe_pin_out,
	output logic [SAMPM_PE_W-1:0]        pe_pin_oe_out,
	output logic [SAMPM_PE_W-1:0]        pe_gpio_in_out,
	output logic [1:0]                   boot_width_strap_out,
	output logic                         clock_source_strap_out
);

	// ************************************************************
	// Mode decode
	// ************************************************************
	sampm_mode_type mode;

	always_comb begin
		if (audio_function_select_in) begin // R2
			mode = SAMPM_MODE_AUDIO;
		end else if (serial_function_select_in) begin // R1
			mode = SAMPM_MODE_CODEC;
		end else begin
			mode = SAMPM_MODE_SSI;
		end
	end

	// ************************************************************
	// Shared serial pins
	// ************************************************************
	always_comb begin
		ser_clk_pin_out     = 1'b0;
		ser_clk_pin_oe_out  = 1'b0;
		ser_txd_pin_out     = 1'b0;
		ser_txfr_pin_out    = 1'b0;
		ser_txfr_pin_oe_out = 1'b0;
		aud_bclk_out        = 1'b0;
		aud_sdi_out         = 1'b0;
		aud_lr_out          = 1'b0;
		aud_mclk_out        = 1'b0;
		ssp_clk_out         = 1'b0;
		ssp_rxd_out         = 1'b0;
		ssp_txfr_out        = 1'b0;
		ssp_rxfr_out        = 1'b0;
		cdc_clk_out         = 1'b0;
		cdc_din_out         = 1'b0;
		cdc_sync_out        = 1'b0;
		case (mode)
			SAMPM_MODE_AUDIO: begin
				ser_clk_pin_out     = aud_bclk_in; // R3
				ser_clk_pin_oe_out  = aud_bclk_oe_in;
				aud_bclk_out        = ser_clk_pin_in;
				ser_txd_pin_out     = aud_sdo_in; // R4
				aud_sdi_out         = ser_rxd_pin_in; // R5
				ser_txfr_pin_out    = aud_lr_in; // R6
				ser_txfr_pin_oe_out = aud_lr_oe_in;
				aud_lr_out          = ser_txfr_pin_in;
				aud_mclk_out        = ser_rxfr_pin_in; // R7
			end
			SAMPM_MODE_CODEC: begin
				ser_clk_pin_out     = cdc_clk_in; // R3
				ser_clk_pin_oe_out  = cdc_clk_oe_in;
				cdc_clk_out         = ser_clk_pin_in;
				ser_txd_pin_out     = cdc_dout_in; // R4
				cdc_din_out         = ser_rxd_pin_in; // R5
				ser_txfr_pin_out    = cdc_sync_in; // R6
				ser_txfr_pin_oe_out = cdc_sync_oe_in;
				cdc_sync_out        = ser_txfr_pin_in;
			end
			default: begin
				ser_clk_pin_out     = ssp_clk_in; // R3
				ser_clk_pin_oe_out  = ssp_clk_oe_in;
				ssp_clk_out         = ser_clk_pin_in;
				ser_txd_pin_out     = ssp_txd_in; // R4
				ssp_rxd_out         = ser_rxd_pin_in; // R5
				ser_txfr_pin_out    = ssp_txfr_in; // R6
				ser_txfr_pin_oe_out = ssp_txfr_oe_in;
				ssp_txfr_out        = ser_txfr_pin_in;
				ssp_rxfr_out        = ser_rxfr_pin_in; // R7
			end
		endcase
	end

	// ************************************************************
	// Static / dynamic memory pins
	// ************************************************************
	logic [SAMPM_ADDR_W-1:0] addr_mux;

	always_comb begin
		addr_mux = st_addr_in;
		// Dynamic bit 0 lands on the highest address line
		for (int i = 0; i <= SAMPM_DRA_LO_MSB - SAMPM_DRA_LO_LSB; i++) begin
			if (dyn_active_in) begin // R19
				addr_mux[SAMPM_DRA_LO_MSB - i] = dyn_addr_in[i]; // R11
			end
		end
		if (dyn_active_in) begin
			addr_mux[SAMPM_DRA_HI_MSB] = dyn_addr_in[13]; // R12
			addr_mux[SAMPM_DRA_HI_LSB] = dyn_addr_in[14]; // R12
		end
	end

	always_comb begin
		if (dyn_active_in) begin // R19
			mem_oe_pin_out  = dyn_cas_n_in; // R8
			mem_we_pin_out  = dyn_we_n_in; // R9
			mem_dir_pin_out = dyn_ras_n_in; // R10
		end else if (st_active_in) begin
			mem_oe_pin_out  = st_oe_n_in; // R8
			mem_we_pin_out  = st_we_n_in; // R9
			mem_dir_pin_out = st_write_in; // R10
		end else begin
			// Idle: strobes inactive
			mem_oe_pin_out  = 1'b1;
			mem_we_pin_out  = 1'b1;
			mem_dir_pin_out = 1'b1;
		end
		mem_addr_pin_out = addr_mux;
	end

	// ************************************************************
	// Port D, run pin, media change pin
	// ************************************************************
	always_comb begin
		pd_pin_out     = pd_gpio_out_in;
		pd_pin_oe_out  = pd_gpio_oe_in;
		pd_gpio_in_out = pd_pin_in;
		if (dyn_mask_en_in) begin
			pd_pin_out[SAMPM_PD_MASK1_BIT]    = dyn_mask_in[1]; // R13
			pd_pin_out[SAMPM_PD_MASK0_BIT]    = dyn_mask_in[0]; // R13
			pd_pin_oe_out[SAMPM_PD_MASK1_BIT] = 1'b1;
			pd_pin_oe_out[SAMPM_PD_MASK0_BIT] = 1'b1;
		end
		if (led_en_in) begin
			pd_pin_out[SAMPM_PD_LED_BIT]    = led_blink_in; // R16
			pd_pin_oe_out[SAMPM_PD_LED_BIT] = 1'b1;
		end
		run_pin_out          = clock_enable_out_sel_in ? clock_enable_out_in : run_in; // R14
		media_change_irq_out = medchg_pin_in; // R15
		boot_rom_select_out  = medchg_pin_in; // R15
	end

	// ************************************************************
	// Port E and strap capture
	// ************************************************************
	logic [SAMPM_PE_W-1:0] pe_s1_q, pe_s2_q, pe_s3_q;
	logic [SAMPM_PE_W-1:0] pe_s1_d, pe_s2_d, pe_s3_d;
	logic [SAMPM_PE_W-1:0] pe_stable_q, pe_stable_d;
	logic                  in_reset_q, in_reset_d;
	logic [1:0]            bootw_q, bootw_d;
	logic                  clksrc_q, clksrc_d;

	always_comb begin
		pe_s1_d     = pe_pin_in;
		pe_s2_d     = pe_s1_q;
		pe_s3_d     = pe_s2_q;
		pe_stable_d = pe_stable_q;
		for (int i = 0; i < SAMPM_PE_W; i++) begin
			if (pe_s2_q[i] == pe_s3_q[i]) begin
				pe_stable_d[i] = pe_s2_q[i];
			end
		end
		in_reset_d = 1'b0;
		bootw_d    = bootw_q;
		clksrc_d   = clksrc_q;
		// Straps from pin levels filtered while reset was low
		if (in_reset_q) begin // R20
			bootw_d  = pe_stable_d[1:0]; // R17
			clksrc_d = pe_stable_d[SAMPM_PE_CLOCK_SOURCE_STRAP_BIT]; // R18
		end
	end

	// Filter has no reset so it keeps sampling straps during reset
	always_ff @(posedge ref_clk_in) begin
		if (clk_en_in) begin
			pe_s1_q <= pe_s1_d;
			pe_s2_q <= pe_s2_d; // R20
			pe_s3_q <= pe_s3_d;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pe_stable_q <= SAMPM_SYNC_RST;
			in_reset_q  <= SAMPM_STRAP_OPEN;
			bootw_q     <= SAMPM_BOOTW_RST;
			clksrc_q    <= SAMPM_CLKSRC_RST;
		end else if (clk_en_in) begin
			pe_stable_q <= pe_stable_d;
			in_reset_q  <= in_reset_d;
			bootw_q     <= bootw_d;
			clksrc_q    <= clksrc_d;
		end
	end

	// Pins are inputs while straps are captured, GPIO afterwards
	always_comb begin
		pe_pin_out             = pe_gpio_out_in;
		pe_pin_oe_out          = in_reset_q ? '0 : pe_gpio_oe_in; // R20
		pe_gpio_in_out         = pe_stable_q;
		boot_width_strap_out   = bootw_q;
		clock_source_strap_out = clksrc_q;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	audio_clk_route_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		audio_function_select_in |-> ser_clk_pin_out == aud_bclk_in) // R3
		else $error("audio clock not routed");
	codec_sel_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(!audio_function_select_in && serial_function_select_in)
		|-> ser_txd_pin_out == cdc_dout_in) // R1
		else $error("codec data not routed");
	ssp_rx_route_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(!audio_function_select_in && !serial_function_select_in)
		|-> ssp_rxd_out == ser_rxd_pin_in && aud_sdi_out == 1'b0) // R5
		else $error("serial receive not routed");
	audio_frame_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		audio_function_select_in |-> ser_txfr_pin_oe_out == aud_lr_oe_in
		&& aud_mclk_out == ser_rxfr_pin_in) // R6
		else $error("audio frame pins wrong");
	codec_rxfr_unused_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(!audio_function_select_in && serial_function_select_in)
		|-> !ssp_rxfr_out && !aud_mclk_out) // R7
		else $error("receive frame leaks in codec mode");
	dyn_strobes_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		dyn_active_in |-> mem_oe_pin_out == dyn_cas_n_in
		&& mem_dir_pin_out == dyn_ras_n_in
		&& mem_addr_pin_out[27] == dyn_addr_in[0]) // R19
		else $error("dynamic cycle pins wrong");
	dyn_addr_hi_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		dyn_active_in |-> mem_addr_pin_out[13] == dyn_addr_in[14]) // R12
		else $error("dynamic high address wrong");
	static_we_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(st_active_in && !dyn_active_in) |-> mem_we_pin_out == st_we_n_in) // R9
		else $error("static write enable wrong");
	strap_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(!in_reset_q && clk_en_in) |=> $stable(boot_width_strap_out)) // R17
		else $error("strap changed after capture");
	led_route_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		led_en_in |-> pd_pin_out[0] == led_blink_in && pd_pin_oe_out[0]) // R16
		else $error("led output not routed");

endmodule : sampm_pin_mux

// ---- common/sampm_pkg.sv ----
// Purpose: Constants for the serial, audio and memory pin sharing block
// Assumes: One clock domain, no register bus
// Notes:   Mode encodings and field positions used by the mux
package sampm_pkg;
	// ************************************************************
	// Serial pin modes
	// ************************************************************
	typedef enum logic [1:0] {
		SAMPM_MODE_SSI   = 2'h0,
		SAMPM_MODE_CODEC = 2'h1,
		SAMPM_MODE_AUDIO = 2'h2
	} sampm_mode_type;

	// ************************************************************
	// Widths, field positions and reset values
	// ************************************************************
	localparam int          SAMPM_ADDR_W        = 28;
	localparam int          SAMPM_DRA_W         = 15;
	localparam int          SAMPM_DRA_LO_MSB    = 27;
	localparam int          SAMPM_DRA_LO_LSB    = 15;
	localparam int          SAMPM_DRA_HI_MSB    = 14;
	localparam int          SAMPM_DRA_HI_LSB    = 13;
	localparam int          SAMPM_PD_W          = 8;
	localparam int          SAMPM_PE_W          = 3;
	localparam int          SAMPM_PD_MASK1_BIT  = 7;
	localparam int          SAMPM_PD_MASK0_BIT  = 6;
	localparam int          SAMPM_PD_LED_BIT    = 0;
	localparam int          SAMPM_PE_CLOCK_SOURCE_STRAP_BIT = 2;
	localparam logic [1:0]  SAMPM_BOOTW_RST     = 2'h0;
	localparam logic        SAMPM_CLKSRC_RST    = 1'h0;
	localparam logic [2:0]  SAMPM_SYNC_RST      = 3'h0;
	localparam logic        SAMPM_STRAP_OPEN    = 1'h1;
endpackage : sampm_pkg

// ---- bench/sampm_ext_model.sv ----
// Purpose: Far-side model of the shared two-way pins
// Assumes: Weak pull-ups on every shared pin
// Notes:   Two drivers at once resolve to unknown
`timescale 1ns/100ps
module sampm_ext_model
	import sampm_pkg::*;
(
	// Device side drivers
	input  wire logic [12:0] dev_val_in,
	input  wire logic [12:0] dev_oe_in,
	// External drivers
	input  wire logic [12:0] ext_val_in,
	input  wire logic [12:0] ext_oe_in,
	// Resolved pin levels
	output logic [12:0]      pin_out
);
	// ************************************************************
	// Pin resolution
	// ************************************************************
	always_comb begin
		for (int i = 0; i < 13; i++) begin
			if (dev_oe_in[i] && ext_oe_in[i])
				pin_out[i] = 1'bx;
			else if (dev_oe_in[i])
				pin_out[i] = dev_val_in[i];
			else if (ext_oe_in[i])
				pin_out[i] = ext_val_in[i];
			else
				pin_out[i] = 1'b1;
		end
	end
endmodule : sampm_ext_model

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the pin sharing block
// Assumes: Shared pins resolved by the far-side model
// Notes:   Straps expected from pin levels held during reset
`timescale 1ns/100ps
module tb_top
	import sampm_pkg::*;
;
	logic nrst_in, ref_clk_in, clk_en_in, serial_function_select_in, audio_function_select_in;
	logic aud_bclk_in, aud_bclk_oe_in, aud_sdo_in, aud_lr_in, aud_lr_oe_in;
	logic ssp_clk_in, ssp_clk_oe_in, ssp_txd_in, ssp_txfr_in, ssp_txfr_oe_in;
	logic cdc_clk_in, cdc_clk_oe_in, cdc_dout_in, cdc_sync_in, cdc_sync_oe_in;
	logic st_active_in, st_oe_n_in, st_we_n_in, st_write_in, dyn_active_in;
	logic dyn_cas_n_in, dyn_we_n_in, dyn_ras_n_in, dyn_mask_en_in, led_blink_in, led_en_in;
	logic run_in, clock_enable_out_in, clock_enable_out_sel_in, medchg_pin_in, ser_rxd_pin_in, ser_rxfr_pin_in;
	logic ser_clk_pin_out, ser_clk_pin_oe_out, ser_txd_pin_out, ser_txfr_pin_out;
	logic ser_txfr_pin_oe_out, aud_bclk_out, aud_sdi_out, aud_lr_out, aud_mclk_out;
	logic ssp_clk_out, ssp_rxd_out, ssp_txfr_out, ssp_rxfr_out, cdc_clk_out, cdc_din_out;
	logic cdc_sync_out, mem_oe_pin_out, mem_we_pin_out, mem_dir_pin_out, run_pin_out;
	logic media_change_irq_out, boot_rom_select_out, clock_source_strap_out;
	logic ext_clk, ext_clk_oe, ext_fr, ext_fr_oe;
	logic [27:0] st_addr_in, mem_addr_pin_out;
	logic [14:0] dyn_addr_in;
	logic [1:0]  dyn_mask_in, boot_width_strap_out;
	logic [7:0]  pd_gpio_out_in, pd_gpio_oe_in, pd_pin_out, pd_pin_oe_out, pd_gpio_in_out;
	logic [7:0]  pd_ext, pd_ext_oe;
	logic [2:0]  pe_gpio_out_in, pe_gpio_oe_in, pe_pin_out, pe_pin_oe_out, pe_gpio_in_out;
	logic [2:0]  pe_ext, pe_ext_oe;
	wire logic   ser_clk_pin_in, ser_txfr_pin_in;
	wire logic [7:0] pd_pin_in;
	wire logic [2:0] pe_pin_in;
	int          mismatches = 0;
	int          samples_checked = 0;

	sampm_pin_mux dut (
		.ref_clk_in, .nrst_in, .clk_en_in, .serial_function_select_in,
		.audio_function_select_in, .ser_clk_pin_in, .ser_clk_pin_out, .ser_clk_pin_oe_out,
		.ser_txd_pin_out, .ser_rxd_pin_in, .ser_txfr_pin_in, .ser_txfr_pin_out,
		.ser_txfr_pin_oe_out, .ser_rxfr_pin_in, .aud_bclk_in, .aud_bclk_oe_in, .aud_bclk_out,
		.aud_sdo_in, .aud_sdi_out, .aud_lr_in, .aud_lr_oe_in, .aud_lr_out, .aud_mclk_out,
		.ssp_clk_in, .ssp_clk_oe_in, .ssp_clk_out, .ssp_txd_in, .ssp_rxd_out, .ssp_txfr_in,
		.ssp_txfr_oe_in, .ssp_txfr_out, .ssp_rxfr_out, .cdc_clk_in, .cdc_clk_oe_in,
		.cdc_clk_out, .cdc_dout_in, .cdc_din_out, .cdc_sync_in, .cdc_sync_oe_in, .cdc_sync_out,
		.st_active_in, .st_oe_n_in, .st_we_n_in, .st_write_in, .st_addr_in, .dyn_active_in,
		.dyn_cas_n_in, .dyn_we_n_in, .dyn_ras_n_in, .dyn_addr_in, .dyn_mask_in, .dyn_mask_en_in,
		.mem_oe_pin_out, .mem_we_pin_out, .mem_dir_pin_out, .mem_addr_pin_out, .pd_gpio_out_in,
		.pd_gpio_oe_in, .pd_pin_in, .pd_pin_out, .pd_pin_oe_out, .pd_gpio_in_out, .led_blink_in,
		.led_en_in, .run_in, .clock_enable_out_in, .clock_enable_out_sel_in, .run_pin_out, .medchg_pin_in,
		.media_change_irq_out, .boot_rom_select_out, .pe_gpio_out_in, .pe_gpio_oe_in,
		.pe_pin_in, .pe_pin_out, .pe_pin_oe_out, .pe_gpio_in_out, .boot_width_strap_out,
		.clock_source_strap_out
	);

	sampm_ext_model ext (
		.dev_val_in ({ser_clk_pin_out, ser_txfr_pin_out, pd_pin_out, pe_pin_out}),
		.dev_oe_in  ({ser_clk_pin_oe_out, ser_txfr_pin_oe_out, pd_pin_oe_out, pe_pin_oe_out}),
		.ext_val_in ({ext_clk, ext_fr, pd_ext, pe_ext}),
		.ext_oe_in  ({ext_clk_oe, ext_fr_oe, pd_ext_oe, pe_ext_oe}),
		.pin_out    ({ser_clk_pin_in, ser_txfr_pin_in, pd_pin_in, pe_pin_in})
	);

	// ************************************************************
	// Clock, compare and closing
	// ************************************************************
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic do_reset(input logic [2:0] s);
		@(posedge ref_clk_in);
		{pe_ext_oe, pe_ext, pe_gpio_oe_in, nrst_in} <= {3'h7, s, 3'h0, 1'b0};
		repeat (6) @(negedge ref_clk_in);
		check(pe_pin_oe_out, 3'h0);
		@(posedge ref_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(negedge ref_clk_in);
		check({boot_width_strap_out, clock_source_strap_out}, {s[1:0], s[2]});
	endtask : do_reset

	task automatic serial_mode(input logic [1:0] c, input logic v);
		logic [2:0] s;
		logic [2:0] p;
		s = c[1] ? 3'h4 : (c[0] ? 3'h1 : 3'h2);
		p = (s & {3{v}}) | (~s & {3{~v}});
		@(posedge ref_clk_in);
		{audio_function_select_in, serial_function_select_in} <= c;
		{aud_bclk_in, ssp_clk_in, cdc_clk_in} <= p;
		{aud_bclk_oe_in, ssp_clk_oe_in, cdc_clk_oe_in} <= p;
		{aud_sdo_in, ssp_txd_in, cdc_dout_in} <= p;
		{aud_lr_in, ssp_txfr_in, cdc_sync_in} <= p;
		{aud_lr_oe_in, ssp_txfr_oe_in, cdc_sync_oe_in} <= p;
		{ser_rxd_pin_in, ser_rxfr_pin_in, ext_clk, ext_fr} <= {4{v}};
		{ext_clk_oe, ext_fr_oe} <= {2{~v}};
		@(negedge ref_clk_in);
		check({ser_clk_pin_oe_out, ser_txfr_pin_oe_out, ser_txd_pin_out}, {3{v}});
		check({ser_clk_pin_in, ser_txfr_pin_in}, {2{v}});
		check({aud_bclk_out, ssp_clk_out, cdc_clk_out}, s & {3{v}});
		check({aud_sdi_out, ssp_rxd_out, cdc_din_out}, s & {3{v}});
		check({aud_lr_out, ssp_txfr_out, cdc_sync_out}, s & {3{v}});
		check({aud_mclk_out, ssp_rxfr_out}, s[2:1] & {2{v}});
	endtask : serial_mode

	task automatic mem_cycle(input logic sa, input logic da);
		logic [27:0] e;
		@(posedge ref_clk_in);
		{st_active_in, dyn_active_in} <= {sa, da};
		@(negedge ref_clk_in);
		for (int i = 0; i < 13; i++)
			e[27-i] = dyn_addr_in[i];
		{e[14], e[13]} = {dyn_addr_in[13], dyn_addr_in[14]};
		if (da) begin
			check({mem_oe_pin_out, mem_we_pin_out, mem_dir_pin_out}, 3'h4);
			check(mem_addr_pin_out[27:13], e[27:13]);
		end else if (sa) begin
			check({mem_oe_pin_out, mem_we_pin_out, mem_dir_pin_out}, 3'h3);
			check(mem_addr_pin_out, st_addr_in);
		end else
			check({mem_oe_pin_out, mem_we_pin_out, mem_dir_pin_out}, 3'h7);
	endtask : mem_cycle

	initial begin
		repeat (3000) @(posedge ref_clk_in);
		mismatches++;
		wrap_up();
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		{serial_function_select_in, audio_function_select_in, aud_bclk_in, aud_bclk_oe_in,
		 aud_sdo_in, aud_lr_in, aud_lr_oe_in, ssp_clk_in, ssp_clk_oe_in, ssp_txd_in,
		 ssp_txfr_in, ssp_txfr_oe_in, cdc_clk_in, cdc_clk_oe_in, cdc_dout_in, cdc_sync_in,
		 cdc_sync_oe_in, st_active_in, dyn_active_in, dyn_mask_en_in, led_blink_in, led_en_in,
		 run_in, clock_enable_out_in, clock_enable_out_sel_in, medchg_pin_in, ser_rxd_pin_in, ser_rxfr_pin_in,
		 ext_clk, ext_clk_oe, ext_fr, ext_fr_oe, dyn_mask_in, pd_gpio_out_in, pd_gpio_oe_in,
		 pd_ext, pd_ext_oe, pe_gpio_out_in, pe_gpio_oe_in} = '0;
		{nrst_in, clk_en_in, st_oe_n_in, st_we_n_in, st_write_in} = 5'h0b;
		{dyn_cas_n_in, dyn_we_n_in, dyn_ras_n_in, pe_ext_oe, pe_ext} = 9'h13d;
		st_addr_in = 28'h5a5a5a5;
		dyn_addr_in = 15'h4b2d;
		do_reset(3'h5);
		for (int c = 0; c < 8; c++)
			serial_mode(c[2:1], c[0]);
		for (int m = 0; m < 4; m++)
			mem_cycle(m[1], m[0]);
		@(posedge ref_clk_in);
		{pd_gpio_out_in, pd_gpio_oe_in, dyn_mask_in} <= {8'h3c, 8'hff, 2'h2};
		{dyn_mask_en_in, led_en_in, led_blink_in} <= 3'h7;
		@(negedge ref_clk_in);
		check({pd_pin_out, pd_pin_in}, 16'hbdbd);
		@(posedge ref_clk_in);
		{dyn_mask_en_in, led_en_in} <= 2'h0;
		@(negedge ref_clk_in);
		check(pd_pin_out, 8'h3c);
		@(posedge ref_clk_in);
		{pd_gpio_oe_in, pd_ext_oe, pd_ext} <= {8'h00, 8'hff, 8'ha5};
		@(negedge ref_clk_in);
		check({pd_pin_oe_out, pd_gpio_in_out}, 16'h00a5);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk_in);
			{clock_enable_out_sel_in, run_in, clock_enable_out_in, medchg_pin_in} <= {k[0], ~k[0], k[0], k[0]};
			@(negedge ref_clk_in);
			check(run_pin_out, 1'b1);
			check({media_change_irq_out, boot_rom_select_out}, {2{k[0]}});
		end
		@(posedge ref_clk_in);
		{pe_ext_oe, pe_gpio_oe_in, pe_gpio_out_in} <= {3'h0, 3'h7, 3'h2};
		repeat (5) @(negedge ref_clk_in);
		check({pe_pin_oe_out, pe_pin_in, pe_gpio_in_out}, {3'h7, 3'h2, 3'h2});
		@(posedge ref_clk_in);
		pe_gpio_oe_in <= 3'h0;
		repeat (3) @(posedge ref_clk_in);
		{clk_en_in, pe_ext_oe, pe_ext} <= {1'b0, 3'h7, 3'h4};
		repeat (6) @(negedge ref_clk_in);
		check(pe_gpio_in_out, 3'h2);
		@(posedge ref_clk_in);
		clk_en_in <= 1'b1;
		repeat (5) @(negedge ref_clk_in);
		check(pe_gpio_in_out, 3'h4);
		do_reset(3'h2);
		wrap_up();
	end
endmodule : tb_top
